// ### hw/pse_mode_reset_control.sv
`timescale 1ns/1ps
module pse_mode_reset_control
    import pse_mode_reset_pkg::*;
#(
    parameter int IF_CYCLES = IF_ACTIVE_CYCLES,
    parameter int CORE_CYCLES = CORE_RESET_CYCLES,
    parameter int RETRY_CYCLES = BACKOFF_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Board pins
    input wire logic i_external_reset_override_n,
    input wire logic i_supplies_good,
    input wire logic i_operating_mode_select,
    input wire logic i_retry_backoff_select,
    input wire logic i_watchdog_disable_strap,
    input wire logic [ADDR_BITS-1:0] i_bus_addr_strap,
    // Bus address match request
    input wire logic i_addr_valid,
    input wire logic [ADDR_BITS-1:0] i_addr_field,
    input wire logic i_bus_clk_activity,
    input wire logic i_osc_activity,
    // Port engine handshake
    input wire logic [NUM_PORTS-1:0] i_port_fault,
    input wire logic i_step_done,
    input wire logic i_step_fail,
    // Host-managed port controls
    input wire logic [NUM_PORTS-1:0] i_host_port_enable,
    // Outputs
    output logic o_fault_alert_n,
    output logic o_fault_alert_oe,
    output logic o_if_reset,
    output logic o_core_reset,
    output logic o_host_managed_mode,
    output logic o_addr_match,
    output logic [ADDR_BITS-1:0] o_bus_addr,
    output logic o_wd_watch_bus_clk,
    output logic o_wd_watch_osc,
    output logic [1:0] o_port_sel,
    output logic o_discover,
    output logic o_classify,
    output logic o_power_on,
    output logic [NUM_PORTS-1:0] o_port_power_enable
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Pull-downs make a floating pin low; the model sees a plain 0
    // Each pin gets its own flops; gating two raw pins first could glitch into the first stage
    localparam int SW = ADDR_BITS + NUM_PORTS + 5;
    logic [SW-1:0] sync_a, sync_b, next_sync_a;
    always_comb begin
        next_sync_a = {i_bus_addr_strap, i_port_fault, i_external_reset_override_n,
                       i_supplies_good, i_operating_mode_select, i_retry_backoff_select,
                       i_watchdog_disable_strap};
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= sync_a;
        end
    end
    logic [ADDR_BITS-1:0] s_addr;
    logic [NUM_PORTS-1:0] s_fault;
    logic s_ovr_n, s_sup_ok, s_run, s_mode, s_backoff, s_watchdog_disable_strap;
    assign {s_addr, s_fault, s_ovr_n, s_sup_ok, s_mode, s_backoff, s_watchdog_disable_strap} = sync_b;
    assign s_run = s_ovr_n && s_sup_ok;

    // ************************************************************
    // Reset delay
    // ************************************************************
    // Interface released early so the host can preset registers
    logic [31:0] rst_cnt, next_rst_cnt;
    logic if_rst, core_rst, next_if_rst, next_core_rst;
    logic [ADDR_BITS-1:0] addr, next_addr;
    always_comb begin
        next_rst_cnt = rst_cnt;
        next_if_rst = if_rst;
        next_core_rst = core_rst;
        next_addr = addr;
        if (!s_run) begin
            next_rst_cnt = '0;
            next_if_rst = 1'b1;
            next_core_rst = 1'b1;
        end else begin
            if (rst_cnt < 32'(CORE_CYCLES)) next_rst_cnt = rst_cnt + 32'h0000_0001;
            if (if_rst && rst_cnt >= 32'(IF_CYCLES - 1)) begin
                next_if_rst = 1'b0;
                next_addr = s_addr;
            end
            if (rst_cnt >= 32'(CORE_CYCLES - 1)) next_core_rst = 1'b0;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rst_cnt <= '0;
            if_rst <= 1'b1;
            core_rst <= 1'b1;
            addr <= ADDR_RESET;
        end else begin
            rst_cnt <= next_rst_cnt;
            if_rst <= next_if_rst;
            core_rst <= next_core_rst;
            addr <= next_addr;
        end
    end
    assign o_if_reset = if_rst;
    assign o_core_reset = core_rst;
    assign o_bus_addr = addr;
    assign o_addr_match = i_addr_valid && !if_rst && (i_addr_field == addr);

    // ************************************************************
    // Mode, watchdog and alert
    // ************************************************************
    assign o_host_managed_mode = s_mode;
    assign o_wd_watch_bus_clk = !s_watchdog_disable_strap && s_mode && !core_rst;
    assign o_wd_watch_osc = !s_watchdog_disable_strap && !core_rst;
    // Open drain: drive low only, never high
    assign o_fault_alert_n = 1'b0;
    assign o_fault_alert_oe = |s_fault;

    // ************************************************************
    // Automatic sequencer
    // ************************************************************
    seq_state_t state, next_state;
    logic [1:0] port, next_port;
    logic [31:0] wait_cnt, next_wait_cnt;
    logic [NUM_PORTS-1:0] pwr, next_pwr;
    always_comb begin
        next_state = state;
        next_port = port;
        next_wait_cnt = wait_cnt;
        next_pwr = pwr;
        if (core_rst) begin
            next_state = ST_IDLE;
            next_port = PORT_RESET;
            next_wait_cnt = '0;
            next_pwr = '0;
        end else if (s_mode) begin
            next_state = ST_IDLE;
            next_pwr = i_host_port_enable;
        end else begin
            case (state)
                ST_IDLE: next_state = ST_DISCOVER;
                ST_DISCOVER: begin
                    if (i_step_fail) begin
                        if (s_backoff) begin
                            next_state = ST_BACKOFF;
                            next_wait_cnt = '0;
                        end else begin
                            next_state = ST_DISCOVER;
                        end
                    end else if (i_step_done) begin
                        next_state = ST_CLASSIFY;
                    end
                end
                ST_CLASSIFY: if (i_step_done) next_state = ST_POWER;
                ST_POWER: begin
                    if (i_step_done) begin
                        next_pwr[port] = 1'b1;
                        next_port = port + 2'h1;
                        next_state = ST_DISCOVER;
                    end
                end
                ST_BACKOFF: begin
                    if (wait_cnt >= 32'(RETRY_CYCLES - 1)) next_state = ST_DISCOVER;
                    else next_wait_cnt = wait_cnt + 32'h0000_0001;
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
            port <= PORT_RESET;
            wait_cnt <= '0;
            pwr <= '0;
        end else begin
            state <= next_state;
            port <= next_port;
            wait_cnt <= next_wait_cnt;
            pwr <= next_pwr;
        end
    end
    assign o_port_sel = port;
    assign o_discover = (state == ST_DISCOVER);
    assign o_classify = (state == ST_CLASSIFY);
    assign o_power_on = (state == ST_POWER);
    assign o_port_power_enable = pwr;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence fail_with_backoff;
        (state == ST_DISCOVER) && i_step_fail && s_backoff && !s_mode && !core_rst;
    endsequence
    AST_ALERT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !$past(i_reset) && !$past(i_reset, 2)
        |-> o_fault_alert_oe == (|$past(i_port_fault, 2)) && !o_fault_alert_n)
        else $error("alert mismatch");
    AST_NO_BACKOFF: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state == ST_DISCOVER) && i_step_fail && !s_backoff && !s_mode && !core_rst
        |=> state == ST_DISCOVER) else $error("retry not immediate");
    AST_BACKOFF: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        fail_with_backoff |=> state == ST_BACKOFF) else $error("no backoff");
    AST_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !s_run |=> if_rst && core_rst) else $error("reset not held");
    AST_IF_FIRST: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !core_rst |-> !if_rst) else $error("core before interface");
    AST_MATCH: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_addr_match |-> i_addr_field == addr) else $error("bad address match");
    AST_ADDR_HELD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !if_rst && !$past(if_rst) |-> $stable(addr)) else $error("address moved while active");
    AST_HOST: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        s_mode && !core_rst |=> pwr == $past(i_host_port_enable)) else $error("host control");
    AST_WD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_wd_watch_bus_clk |-> s_mode && o_wd_watch_osc) else $error("watchdog mode");
endmodule : pse_mode_reset_control

// ### hw/pse_mode_reset_pkg.sv
package pse_mode_reset_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int IF_ACTIVE_US = 70;
    localparam int IF_ACTIVE_CYCLES = (IF_ACTIVE_US * (CLK_HZ / 1_000_000));
    localparam int CORE_RESET_S = 1;
    localparam int CORE_RESET_CYCLES = CORE_RESET_S * CLK_HZ;
    localparam int BACKOFF_S = 2;
    localparam int BACKOFF_CYCLES = BACKOFF_S * CLK_HZ;
    localparam int NUM_PORTS = 4;
    localparam int ADDR_BITS = 5;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam logic [1:0] PORT_RESET = 2'h0;
    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DISCOVER = 5'b00010,
        ST_CLASSIFY = 5'b00100,
        ST_POWER = 5'b01000,
        ST_BACKOFF = 5'b10000
    } seq_state_t;
endpackage : pse_mode_reset_pkg

// ### testbench/port_engine_model.sv
`timescale 1ns/1ps
module port_engine_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Step requests
    input wire logic i_discover,
    input wire logic i_classify,
    input wire logic i_power_on,
    input wire logic i_fail_mode,
    // Step answers
    output logic o_step_done,
    output logic o_step_fail
);
    logic [1:0] wait_cnt;
    // A step answers after four cycles, or three when it directly follows an answered step, so the sequencer never sees instant replies
    always_ff @(posedge i_sys_clk) begin
        o_step_done <= 1'b0;
        o_step_fail <= 1'b0;
        wait_cnt <= 2'h0;
        if (!i_reset && (i_discover || i_classify || i_power_on)) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == 2'h3) begin
                wait_cnt <= 2'h0;
                o_step_fail <= i_discover && i_fail_mode;
                o_step_done <= !(i_discover && i_fail_mode);
            end
        end
    end
endmodule : port_engine_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import pse_mode_reset_pkg::*;
    localparam int IFC = 20;
    localparam int CORC = 100;
    localparam int RETC = 50;
    logic clk, rst, ovr_n, sup, mode, bko, wdd, av, fail, done, sfail;
    logic [4:0] strap, field;
    logic [3:0] pfault, hen, pen;
    logic alert_n, alert_oe, if_rst, core_rst, hmm, match, wbus, wosc, disc, cls, pwr;
    logic [4:0] baddr;
    logic [1:0] psel;
    int bad_count, cmp_count, n;
    pse_mode_reset_control #(.IF_CYCLES(IFC), .CORE_CYCLES(CORC), .RETRY_CYCLES(RETC)) uut (
        .i_sys_clk(clk), .i_reset(rst), .i_external_reset_override_n(ovr_n),
        .i_supplies_good(sup), .i_operating_mode_select(mode), .i_retry_backoff_select(bko),
        .i_watchdog_disable_strap(wdd), .i_bus_addr_strap(strap), .i_addr_valid(av),
        .i_addr_field(field), .i_bus_clk_activity(1'b0), .i_osc_activity(1'b0),
        .i_port_fault(pfault), .i_step_done(done), .i_step_fail(sfail),
        .i_host_port_enable(hen), .o_fault_alert_n(alert_n), .o_fault_alert_oe(alert_oe),
        .o_if_reset(if_rst), .o_core_reset(core_rst), .o_host_managed_mode(hmm),
        .o_addr_match(match), .o_bus_addr(baddr), .o_wd_watch_bus_clk(wbus),
        .o_wd_watch_osc(wosc), .o_port_sel(psel), .o_discover(disc), .o_classify(cls),
        .o_power_on(pwr), .o_port_power_enable(pen));
    port_engine_model peer (.i_sys_clk(clk), .i_reset(rst), .i_discover(disc),
        .i_classify(cls), .i_power_on(pwr), .i_fail_mode(fail), .o_step_done(done),
        .o_step_fail(sfail));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // ************************************************************
    // Watchdog
    // ************************************************************
    initial begin
        #(20 * 5000);
        bad_count++;
        end_sim();
    end
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        {rst, ovr_n, sup, mode, bko, wdd, av, fail, field, pfault, hen} = '0;
        rst = 1'b1;
        sup = 1'b1;
        strap = 5'h15;
        tick(5);
        rst = 1'b0;
        tick(10);
        check(if_rst, 1'b1);
        check(core_rst, 1'b1);
        check(alert_oe, 1'b0);
        av = 1'b1;
        field = 5'h15;
        tick(1);
        check(match, 1'b0);
        ovr_n = 1'b1;
        n = 0;
        while (if_rst !== 1'b0 && n < 500) begin tick(1); n++; end
        check(n >= IFC && n <= IFC + 4, 1'b1);
        check(core_rst, 1'b1);
        check(baddr, 5'h15);
        check(match, 1'b1);
        field = 5'h14;
        tick(1);
        n++;
        check(match, 1'b0);
        av = 1'b0;
        while (core_rst !== 1'b0 && n < 500) begin tick(1); n++; end
        check(n >= CORC && n <= CORC + 4, 1'b1);
        $display("reset release test done");
        n = 0;
        while (pen !== 4'hF && n < 500) begin tick(1); n++; end
        check(pen, 4'hF);
        check(psel, 2'h0);
        check({hmm, wbus, wosc}, 3'b001);
        pfault = 4'h4;
        tick(3);
        check({alert_oe, alert_n}, 2'b10);
        check({disc, cls, pwr}, 3'b100);
        pfault = 4'h0;
        tick(3);
        check(alert_oe, 1'b0);
        check({disc, cls, pwr}, 3'b010);
        $display("auto mode test done");
        fail = 1'b1;
        n = 0;
        while (disc !== 1'b1 && n < 100) begin tick(1); n++; end
        n = 0;
        repeat (30) begin tick(1); if (disc !== 1'b1) n++; end
        check(n, 0);
        check(psel, 2'h1);
        bko = 1'b1;
        n = 0;
        while (disc !== 1'b0 && n < 100) begin tick(1); n++; end
        n = 0;
        while (disc !== 1'b1 && n < 500) begin tick(1); n++; end
        check(n >= RETC - 4 && n <= RETC + 4, 1'b1);
        $display("backoff test done");
        mode = 1'b1;
        hen = 4'h9;
        tick(4);
        check({hmm, wbus, wosc}, 3'b111);
        check(pen, 4'h9);
        wdd = 1'b1;
        tick(4);
        check({wbus, wosc}, 2'b00);
        ovr_n = 1'b0;
        tick(4);
        check({if_rst, core_rst}, 2'b11);
        $display("host mode test done");
        // Release again with a new strap: address must be resampled
        strap = 5'h0A;
        ovr_n = 1'b1;
        n = 0;
        while (if_rst !== 1'b0 && n < 500) begin tick(1); n++; end
        check(n >= IFC && n <= IFC + 4, 1'b1);
        check(baddr, 5'h0A);
        check(core_rst, 1'b1);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        check({if_rst, core_rst, alert_oe}, 3'b110);
        check(pen, 4'h0);
        $display("mid-run reset test done");
        end_sim();
    end
endmodule : tb
